// ==== hdl/otfr_pkg.sv ====
// otfr_pkg: constants for the overtemperature fault threshold and reaction registers
// assumes a command decoder upstream that presents one command write or read at a time
package otfr_pkg;
    // command codes
    localparam logic [7:0] OTFR_CMD_THRESHOLD = 8'h4F;
    localparam logic [7:0] OTFR_CMD_REACTION = 8'h50;
    // reset values
    localparam logic [15:0] OTFR_THRESHOLD_RESET = 16'h0091;
    localparam logic [7:0] OTFR_REACTION_RESET = 8'h3F;
    // field positions of the reaction register
    localparam int OTFR_RSP_BIT = 7;
    localparam int OTFR_ZERO_BIT = 6;
    localparam int OTFR_RS_HI = 5;
    localparam int OTFR_RS_LO = 3;
    // threshold exponent is fixed zero, so the mantissa is whole degrees
    localparam logic [7:0] OTFR_THRESHOLD_EXP_HI = 8'h00;
    localparam logic [7:0] OTFR_HYSTERESIS = 8'h14;
    localparam logic [3:0] OTFR_RETRY_RAMPS = 4'h7;
    localparam logic [2:0] OTFR_RETRY_ON = 3'h7;
    localparam logic [2:0] OTFR_RETRY_OFF = 3'h0;
    // restart state machine
    typedef enum logic [3:0] {
        OTFR_RUN = 4'h1,
        OTFR_OFF = 4'h2,
        OTFR_WAIT = 4'h4,
        OTFR_RESTART = 4'h8
    } otfr_state_t;
endpackage

// ==== hdl/otfr_block.sv ====
// otfr_block: overtemperature fault threshold, reaction, fault latch and restart control
// assumes command strobes are single-cycle and synchronous to i_clock; the soft-start
// sequencer reports each finished ramp by a one-cycle pulse on i_ramp_tick
`timescale 1ns/1ps

// Behaviour
// - fault rises when external temperature exceeds the threshold in degrees
// - threshold write not above warning sets comm fault, invalid data and alert
// - save-all-defaults stores threshold and reaction to nonvolatile memory
// - threshold is a linear word, exponent zero and read-only, low byte writable
// - threshold defaults to 145 degrees
// - fault sets temp summary flag, overtemp fault flag and the alert
// - fault flag holds until temperature drops 20 degrees below threshold
// - reaction: response bit 7, bit 6 zero, retry 5:3, delay 2:0, reset 0x3F
// - ignore response keeps regulating but still flags and alerts
// - response one shuts output down and restarts per retry select
// - retry 000 restarts without delay; output stays off until fault clears
// - retry 111 restarts repeatedly until commanded off or other fault
// - reaction write with retry not 000 or 111 is rejected and flagged
// - only response bit 7 and retry bit 5 are kept in nonvolatile memory
// - retry delay bits read as copies of bit 5
// - delay 111 waits seven soft-start ramps before restarting
// - delay 000 applies no delay and output stays off; in ignore mode a start still waits seven soft-start ramps
// - bandgap faults use the response but are never ignored
module otfr_block
    import otfr_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // command port from the bus decoder
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic i_save_all,
    input wire logic i_restore,
    input wire logic [7:0] i_nv_threshold,
    input wire logic [1:0] i_nv_reaction,
    // system state
    input wire logic [7:0] i_temp_ext,
    input wire logic [7:0] i_overtemp_warning_threshold,
    input wire logic i_bandgap_fault,
    input wire logic i_output_on_cmd,
    input wire logic i_ramp_tick,
    input wire logic i_status_clear,
    // register read-back
    output logic [15:0] o_threshold,
    output logic [7:0] o_reaction,
    // status and alert
    output logic o_temp_summary_flag,
    output logic o_overtemp_fault_flag,
    output logic o_comm_fault_flag,
    output logic o_invalid_data_flag,
    output logic o_alert,
    // power stage control and nonvolatile store
    output logic o_output_enable,
    output logic o_soft_start_req,
    output logic o_nv_write,
    output logic [7:0] o_nv_threshold,
    output logic [1:0] o_nv_reaction
);
    logic [7:0] thr_reg, thr_next;
    logic rsp_reg, rsp_next, rs_reg, rs_next;
    logic fault_reg, fault_next, summ_reg, summ_next;
    logic cml_reg, cml_next, ivd_reg, ivd_next, alert_reg, alert_next;
    logic nvw_reg, nvw_next;
    otfr_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic wr_thr, wr_rea, thr_bad, rea_bad, trip, release_ok, shutdown;
    logic [2:0] rs_field;

    // decode and check incoming writes
    always_comb begin
        wr_thr = i_cmd_write && (i_cmd_code == OTFR_CMD_THRESHOLD);
        wr_rea = i_cmd_write && (i_cmd_code == OTFR_CMD_REACTION);
        thr_bad = i_cmd_wdata[7:0] <= i_overtemp_warning_threshold;
        rs_field = i_cmd_wdata[OTFR_RS_HI:OTFR_RS_LO];
        rea_bad = (rs_field != OTFR_RETRY_ON) && (rs_field != OTFR_RETRY_OFF);
        trip = i_temp_ext > thr_reg;
        // the release test adds the hysteresis to the temperature rather than taking it
        // from the threshold, so a low threshold can never wrap below zero
        release_ok = ({1'b0, i_temp_ext} + 9'(OTFR_HYSTERESIS)) <= {1'b0, thr_reg};
        shutdown = (fault_reg && rsp_reg) || i_bandgap_fault;
    end

    // register contents, flags and alert
    always_comb begin
        thr_next = thr_reg;
        rsp_next = rsp_reg;
        rs_next = rs_reg;
        cml_next = cml_reg;
        ivd_next = ivd_reg;
        alert_next = alert_reg;
        fault_next = fault_reg;
        summ_next = summ_reg;
        nvw_next = i_save_all;
        if (i_status_clear) begin
            cml_next = 1'b0;
            ivd_next = 1'b0;
            summ_next = 1'b0;
            alert_next = 1'b0;
        end
        if (i_restore) begin
            thr_next = i_nv_threshold;
            rsp_next = i_nv_reaction[1];
            rs_next = i_nv_reaction[0];
        end else if (wr_thr) begin
            if (thr_bad) begin
                cml_next = 1'b1;
                ivd_next = 1'b1;
                alert_next = 1'b1;
            end else begin
                thr_next = i_cmd_wdata[7:0];
            end
        end else if (wr_rea) begin
            if (rea_bad) begin
                cml_next = 1'b1;
                ivd_next = 1'b1;
                alert_next = 1'b1;
            end else begin
                rsp_next = i_cmd_wdata[OTFR_RSP_BIT];
                rs_next = i_cmd_wdata[OTFR_RS_HI];
            end
        end
        // set wins over a status clear in the same cycle
        if (trip) begin
            fault_next = 1'b1;
            summ_next = 1'b1;
            alert_next = 1'b1;
        end else if (release_ok) begin
            fault_next = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            thr_reg <= OTFR_THRESHOLD_RESET[7:0];
            rsp_reg <= OTFR_REACTION_RESET[OTFR_RSP_BIT];
            rs_reg <= OTFR_REACTION_RESET[OTFR_RS_HI];
            fault_reg <= 1'b0;
            summ_reg <= 1'b0;
            cml_reg <= 1'b0;
            ivd_reg <= 1'b0;
            alert_reg <= 1'b0;
            nvw_reg <= 1'b0;
        end else begin
            thr_reg <= thr_next;
            rsp_reg <= rsp_next;
            rs_reg <= rs_next;
            fault_reg <= fault_next;
            summ_reg <= summ_next;
            cml_reg <= cml_next;
            ivd_reg <= ivd_next;
            alert_reg <= alert_next;
            nvw_reg <= nvw_next;
        end
    end

    // restart sequencer; ignore mode never leaves run unless the bandgap trips or the output is commanded off
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            OTFR_RUN: begin
                if (shutdown) begin
                    st_next = OTFR_OFF;
                end
            end
            OTFR_OFF: begin
                // wait until cool; retry off holds here until the fault clears
                if (!shutdown && i_output_on_cmd) begin
                    // ignore mode lands here after reset, an off command or a bandgap fault, and then
                    // takes the same delayed start as the retry-on setting
                    if (rs_reg || (!i_bandgap_fault && !rsp_reg)) begin
                        st_next = OTFR_WAIT;
                        cnt_next = 4'h0;
                    end else begin
                        st_next = OTFR_RESTART;
                    end
                end
            end
            OTFR_WAIT: begin
                if (shutdown) begin
                    st_next = OTFR_OFF;
                end else if (i_ramp_tick) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg + 4'h1 >= OTFR_RETRY_RAMPS) begin
                        st_next = OTFR_RESTART;
                    end
                end
            end
            OTFR_RESTART: begin
                st_next = shutdown ? OTFR_OFF : OTFR_RUN;
            end
            default: begin
                st_next = OTFR_RUN;
            end
        endcase
        if (!i_output_on_cmd) begin
            st_next = OTFR_OFF;
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_reg <= OTFR_OFF;
            cnt_reg <= 4'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    // outputs straight from flip-flops
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_output_enable <= 1'b0;
            o_soft_start_req <= 1'b0;
        end else begin
            o_output_enable <= (st_next == OTFR_RUN) || (st_next == OTFR_RESTART);
            o_soft_start_req <= (st_next == OTFR_RESTART);
        end
    end

    always_comb begin
        o_threshold = {OTFR_THRESHOLD_EXP_HI, thr_reg};
        o_reaction = {rsp_reg, 1'b0, {3{rs_reg}}, {3{rs_reg}}};
        o_temp_summary_flag = summ_reg;
        o_overtemp_fault_flag = fault_reg;
        o_comm_fault_flag = cml_reg;
        o_invalid_data_flag = ivd_reg;
        o_alert = alert_reg;
        o_nv_write = nvw_reg;
        o_nv_threshold = thr_reg;
        o_nv_reaction = {rsp_reg, rs_reg};
    end

    // checks on flags and register contents
    a_fault_sets_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        trip |=> o_overtemp_fault_flag && o_alert && o_temp_summary_flag)
        else $error("fault flags not set");
    a_bad_thr_kept: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_thr && thr_bad && !i_restore |=> $stable(o_threshold) && o_invalid_data_flag)
        else $error("rejected threshold changed");
    a_thr_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_thr && !thr_bad && !i_restore
        |=> o_threshold == {OTFR_THRESHOLD_EXP_HI, $past(i_cmd_wdata[7:0])})
        else $error("accepted threshold not stored");
    a_bad_rea_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_rea && rea_bad && !i_restore |=> o_comm_fault_flag && $stable(o_reaction))
        else $error("bad reaction accepted");
    a_bit6_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !o_reaction[OTFR_ZERO_BIT] && (o_reaction[2:0] == o_reaction[5:3]))
        else $error("reaction layout broken");
    a_restore_load: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_restore |=> o_reaction[OTFR_RSP_BIT] == $past(i_nv_reaction[1])
            && o_reaction[OTFR_RS_HI] == $past(i_nv_reaction[0]))
        else $error("restored reaction wrong");
    a_nv_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_save_all |=> o_nv_write)
        else $error("store strobe missing");

    // a clear with nothing new to report drops the alert; a set in the same cycle wins
    a_status_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_status_clear && !trip && !wr_thr && !wr_rea |=> !o_alert && !o_comm_fault_flag)
        else $error("status clear ignored");

    // fault latch and hysteresis
    a_hyst_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_overtemp_fault_flag && !release_ok |=> o_overtemp_fault_flag)
        else $error("fault released early");
    a_hyst_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_overtemp_fault_flag && release_ok |=> !o_overtemp_fault_flag)
        else $error("fault held after cooling");

    // restart steps: a shutdown cause while running, then a quiet power stage
    sequence s_run_shutdown;
        st_reg == OTFR_RUN && shutdown && i_output_on_cmd;
    endsequence
    sequence s_stage_quiet;
        !o_output_enable && !o_soft_start_req;
    endsequence
    a_ignore_runs: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        st_reg == OTFR_RUN && !rsp_reg && !i_bandgap_fault && i_output_on_cmd
        |=> st_reg == OTFR_RUN)
        else $error("ignore mode stopped output");
    a_shut_on_fault: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_run_shutdown |=> s_stage_quiet)
        else $error("output kept on after fault");
    a_retry_off_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        st_reg == OTFR_OFF && shutdown |=> s_stage_quiet)
        else $error("restart while fault stands");
    a_wait_ramps: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        st_reg == OTFR_WAIT && cnt_reg < OTFR_RETRY_RAMPS - 4'h1 |=> !o_soft_start_req)
        else $error("restart before delay ran out");
    a_start_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_soft_start_req |=> !o_soft_start_req)
        else $error("soft-start request too long");
    a_off_cmd: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_output_on_cmd |=> !o_output_enable && cnt_reg == 4'h0)
        else $error("output left on");
    a_bandgap_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_bandgap_fault |=> s_stage_quiet)
        else $error("bandgap fault ignored");
endmodule // otfr_block

// ==== verif/otfr_host_model.sv ====
// otfr_host_model: host side that issues command writes to otfr_block
// assumes the block samples a write on the rising edge where the strobe is high
`timescale 1ns/1ps
module otfr_host_model (
    // clock
    input wire logic i_clock,
    // command lines
    output logic o_cmd_write,
    output logic [7:0] o_cmd_code,
    output logic [15:0] o_cmd_wdata
);
    // idle lines at time zero
    initial begin
        o_cmd_write = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_wdata = 16'h0000;
    end
    // one write; threshold mantissas sent stay within 120 to 165
    // released lines show the inverse, so stale data never looks valid
    task automatic write(input logic [7:0] code, input logic [15:0] data);
        @(posedge i_clock);
        o_cmd_write <= 1'b1;
        o_cmd_code <= code;
        o_cmd_wdata <= data;
        @(posedge i_clock);
        o_cmd_write <= 1'b0;
        o_cmd_code <= ~code;
        o_cmd_wdata <= ~data;
    endtask
endmodule // otfr_host_model

// ==== verif/overtemp_fault_limit_response_tb.sv ====
// overtemp_fault_limit_response_tb: self-checking bench for otfr_block
// assumes the host model issues writes; a ramp tick comes every 8 cycles
`timescale 1ns/1ps
module overtemp_fault_limit_response_tb;
    import otfr_pkg::*;
    logic clock, rst_n, cw, save, rest, bg, on, tick, clr;
    logic ts, of, cml, ivd, alert, en, ss, nvw;
    logic [7:0] code, nthr, temp, warn, nv_thr, rx;
    logic [15:0] wd, thr;
    logic [1:0] nrx, nv_rx;
    logic [2:0] tcnt;
    int fails = 0;
    int compares = 0;
    int starts = 0;
    otfr_host_model host (.i_clock(clock), .o_cmd_write(cw), .o_cmd_code(code), .o_cmd_wdata(wd));
    otfr_block uut (.i_clock(clock), .i_rst_n(rst_n), .i_cmd_write(cw), .i_cmd_code(code),
        .i_cmd_wdata(wd), .i_save_all(save), .i_restore(rest), .i_nv_threshold(nthr),
        .i_nv_reaction(nrx), .i_temp_ext(temp), .i_overtemp_warning_threshold(warn),
        .i_bandgap_fault(bg), .i_output_on_cmd(on), .i_ramp_tick(tick), .i_status_clear(clr),
        .o_threshold(thr), .o_reaction(rx), .o_temp_summary_flag(ts),
        .o_overtemp_fault_flag(of), .o_comm_fault_flag(cml), .o_invalid_data_flag(ivd),
        .o_alert(alert), .o_output_enable(en), .o_soft_start_req(ss), .o_nv_write(nvw),
        .o_nv_threshold(nv_thr), .o_nv_reaction(nv_rx));
    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ramp ticks phased to reset release, so start-up tick counts are exact
    always @(posedge clock) begin
        tcnt <= rst_n ? tcnt + 3'h1 : 3'h0;
        tick <= rst_n && tcnt == 3'h7;
    end
    // soft-start pulses seen, one per restart
    always @(posedge clock) begin
        starts <= starts + ((ss === 1'b1) ? 1 : 0);
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // new temperature at an edge, then let the flags settle
    task automatic set_temp(input logic [7:0] t);
        @(posedge clock);
        temp <= t;
        cyc(2);
    endtask
    // bounded wait for the output enable, counting ramp ticks meanwhile
    task automatic wait_en(output int n);
        n = 0;
        for (int i = 0; i < 300 && en !== 1'b1; i++) begin
            @(posedge clock);
            n += (tick === 1'b1) ? 1 : 0;
        end
        #1;
    endtask
    // one-cycle status clear pulse, then let the flags settle
    task automatic clr_status;
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        #1;
    endtask
    task automatic t_reset;
        int n;
        chk("threshold", thr, 16'h0091);
        chk("reaction", {8'h00, rx}, 16'h003F);
        wait_en(n);
        chk("start ticks", 16'(n), 16'h0007);
        chk("start pulse", 16'(starts), 16'h0001);
    endtask
    task automatic t_thr;
        host.write(OTFR_CMD_THRESHOLD, 16'hFF96);
        #1;
        chk("threshold", thr, 16'h0096);
        host.write(OTFR_CMD_THRESHOLD, 16'h0078);
        #1;
        chk("kept threshold", thr, 16'h0096);
        chk("reject flags", 16'({cml, ivd, alert}), 16'h0007);
        clr_status();
        chk("flags cleared", 16'({cml, ivd, alert}), 16'h0000);
    endtask
    task automatic t_rx;
        for (int p = 1; p < 7; p++) begin
            host.write(OTFR_CMD_REACTION, 16'(p << 3));
            #1;
            chk("reaction kept", {7'h00, ivd, rx}, 16'h013F);
        end
        host.write(OTFR_CMD_REACTION, 16'h00C0);
        #1;
        chk("zero bit", {8'h00, rx}, 16'h0080);
        host.write(OTFR_CMD_REACTION, 16'h0038);
        #1;
        chk("delay copy", {8'h00, rx}, 16'h003F);
    endtask
    task automatic t_fault;
        clr_status();
        set_temp(8'h96);
        chk("no trip", 16'({of, alert}), 16'h0000);
        set_temp(8'h97);
        chk("trip ignore", 16'({of, ts, alert, en}), 16'h000F);
        set_temp(8'h83);
        chk("latched", 16'(of), 16'h0001);
        set_temp(8'h82);
        chk("released", 16'(of), 16'h0000);
    endtask
    task automatic t_shut;
        int n;
        host.write(OTFR_CMD_REACTION, 16'h00BF);
        set_temp(8'h97);
        cyc(2);
        chk("shut down", 16'(en), 16'h0000);
        set_temp(8'h64);
        wait_en(n);
        chk("retry wait", 16'(n >= 7 && n <= 8 && en === 1'b1), 16'h0001);
        host.write(OTFR_CMD_REACTION, 16'h0080);
        set_temp(8'h97);
        cyc(80);
        chk("stays off", 16'(en), 16'h0000);
        set_temp(8'h64);
        wait_en(n);
        chk("no delay", 16'(n <= 1 && en === 1'b1), 16'h0001);
        host.write(OTFR_CMD_REACTION, 16'h003F);
        @(posedge clock);
        bg <= 1'b1;
        cyc(4);
        chk("bandgap off", 16'(en), 16'h0000);
        @(posedge clock);
        bg <= 1'b0;
        on <= 1'b0;
        cyc(80);
        chk("commanded off", 16'(en), 16'h0000);
        @(posedge clock);
        on <= 1'b1;
        wait_en(n);
        chk("on again", 16'(en), 16'h0001);
        chk("restarts", 16'(starts), 16'h0004);
    endtask
    task automatic t_nv;
        @(posedge clock);
        save <= 1'b1;
        @(posedge clock);
        save <= 1'b0;
        #1;
        chk("nv store", {5'h00, nvw, nv_thr, nv_rx}, 16'h0659);
        @(posedge clock);
        nthr <= 8'h8C;
        nrx <= 2'h2;
        rest <= 1'b1;
        @(posedge clock);
        rest <= 1'b0;
        #1;
        chk("restored", {thr[7:0], rx}, 16'h8C80);
    endtask
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge clock);
        fails++;
        end_of_test();
    end
    initial begin
        {rst_n, save, rest, bg, clr, nthr, nrx} = '0;
        on = 1'b1;
        temp = 8'h19;
        warn = 8'h82;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        cyc(1);
        t_reset();
        $display("reset test done");
        t_thr();
        $display("threshold test done");
        t_rx();
        $display("reaction test done");
        t_fault();
        $display("fault test done");
        t_shut();
        $display("shutdown test done");
        t_nv();
        $display("store test done");
        end_of_test();
    end
endmodule // overtemp_fault_limit_response_tb
